// [hdl/otr_pace_if.sv]
// Link between the register slice and its threshold decrement pacer
`timescale 1ns/1ps
`default_nettype none
interface otr_pace_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic [2:0] rate_code;
  logic       decrement_pulse;
  modport ctrl  (input clk, input rst_n, output rate_code, input decrement_pulse);
  modport pacer (input clk, input rst_n, input rate_code, output decrement_pulse);
endinterface : otr_pace_if
`default_nettype wire

// [hdl/otr_pacer.sv]
// Threshold decrement pacer: turns the rate code into decrement pulses
`timescale 1ns/1ps
`default_nettype none
module otr_pacer #(
  parameter int CHIP_LOG2 = 6
) (
  otr_pace_if.pacer pace
);
  logic [CHIP_LOG2-1:0] cycle_reg;
  logic [2:0]           chip_reg;
  logic [CHIP_LOG2-1:0] fast_mask;
  logic [2:0]           slow_mask;
  logic                 fire;
  logic                 pulse_reg;

  // Cycle within a chip period and count of whole chip periods
  always_ff @(posedge pace.clk or negedge pace.rst_n) begin
    if (!pace.rst_n) begin
      cycle_reg <= '0;
      chip_reg  <= '0;
    end else begin
      cycle_reg <= cycle_reg + 1'b1;
      if (&cycle_reg) begin
        chip_reg <= chip_reg + 1'b1;
      end
    end
  end

  // Fast codes divide the chip, slow codes span 1, 2, 4 or 8 chips
  always_comb begin
    fast_mask = {CHIP_LOG2{1'b1}} >> (pace.rate_code - otr_pkg::RATE_FAST_BASE);
    slow_mask = 3'h7 >> (otr_pkg::RATE_SLOW_TOP - pace.rate_code[1:0]);
    if (pace.rate_code >= otr_pkg::RATE_FAST_MIN) begin
      fire = ((cycle_reg & fast_mask) == '0);
    end else begin
      fire = (cycle_reg == '0) && ((chip_reg & slow_mask) == 3'h0);
    end
  end

  // Registered decrement pulse
  always_ff @(posedge pace.clk or negedge pace.rst_n) begin
    if (!pace.rst_n) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= fire;
    end
  end

  assign pace.decrement_pulse = pulse_reg;
endmodule : otr_pacer
`default_nettype wire

// [hdl/otr_pkg.sv]
// Constants shared by the threshold, strength and sync register slice
`default_nettype none
package otr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_STRENGTH    = 8'h14;
  localparam logic [7:0]  IDX_THRESH_CFG  = 8'h15;
  localparam logic [7:0]  IDX_SYNC_HIGH   = 8'h16;
  localparam logic [7:0]  IDX_SYNC_LENGTH = 8'h12;
  localparam int          ADDR_LSB        = 2;
  // Field positions of the threshold configuration register
  localparam int          STEP_HI         = 7;
  localparam int          STEP_LO         = 5;
  localparam int          RATE_HI         = 4;
  localparam int          RATE_LO         = 2;
  localparam int          CUT_HI          = 1;
  localparam int          CUT_LO          = 0;
  // Field position of the sync length select
  localparam int          SLEN_HI         = 4;
  localparam int          SLEN_LO         = 3;
  // Reset values
  localparam logic [7:0]  THRESH_CFG_RST  = 8'h00;
  localparam logic [7:0]  SYNC_HIGH_RST   = 8'h00;
  localparam logic [1:0]  SYNC_LENGTH_RST = 2'h3;
  // Cut-off codes
  localparam logic [1:0]  CUT_BR_8PI      = 2'h0;
  localparam logic [1:0]  CUT_BR_32PI     = 2'h3;
  // Decrement rate codes at and above this count per chip rather than chips per step
  localparam logic [2:0]  RATE_FAST_MIN   = 3'h4;
  localparam logic [1:0]  RATE_SLOW_TOP   = 2'h3;
  localparam logic [2:0]  RATE_FAST_BASE  = 3'h3;
  // Sync length unit in bits
  localparam logic [5:0]  SYNC_BYTE_BITS  = 6'h08;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : otr_pkg
`default_nettype wire

// [hdl/otr_regs.sv]
// Register slice for signal strength, on-off threshold config and sync pattern high byte
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module otr_regs #(
  parameter int ADDR_W    = 12,
  parameter int CHIP_LOG2 = 6
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Measurement from the demodulator, same clock
  input  wire logic [7:0]        strength_value,
  // Configuration towards the demodulator
  output logic [2:0]             threshold_step_size,
  output logic [4:0]             threshold_step_half_db,
  output logic [2:0]             threshold_decrement_rate,
  output logic                   threshold_decrement,
  output logic [1:0]             average_cutoff_select,
  output logic                   average_cutoff_narrow,
  output logic                   average_cutoff_reserved,
  output logic [7:0]             sync_pattern_value,
  output logic [1:0]             sync_length_select,
  output logic [5:0]             sync_length_bits
);
  logic              rst_meta_reg;
  logic              rst_n_reg;
  logic [7:0]        thresh_cfg_reg;
  logic [7:0]        sync_high_reg;
  logic [1:0]        sync_len_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic              waddr_held_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              wdata_held_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  logic [4:0]        step_half_db_reg;
  logic [5:0]        sync_bits_reg;
  logic              do_write;
  logic [7:0]        widx;
  logic [7:0]        ridx;
  logic              wr_hit;
  logic [31:0]       rd_next;
  logic [1:0]        rresp_next;

  // Reset release through two flip-flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  localparam int ADDR_LSB_U = otr_pkg::ADDR_LSB;

  // Write address and data are taken independently, one write in flight
  assign s_axi_awready = !waddr_held_reg && !bvalid_reg;
  assign s_axi_wready  = !wdata_held_reg && !bvalid_reg;
  assign do_write      = waddr_held_reg && wdata_held_reg;
  assign widx          = 8'(waddr_reg >> ADDR_LSB_U);

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      waddr_reg      <= '0;
      waddr_held_reg <= 1'b0;
      wdata_reg      <= '0;
      wstrb_reg      <= '0;
      wdata_held_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        waddr_reg      <= s_axi_awaddr;
        waddr_held_reg <= 1'b1;
      end else if (do_write) begin
        waddr_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg      <= s_axi_wdata;
        wstrb_reg      <= s_axi_wstrb;
        wdata_held_reg <= 1'b1;
      end else if (do_write) begin
        wdata_held_reg <= 1'b0;
      end
    end
  end

  // Write decode; strength index is accepted but changes nothing
  always_comb begin
    if (widx == otr_pkg::IDX_STRENGTH) begin
      wr_hit = 1'b1;
    end else if (widx == otr_pkg::IDX_THRESH_CFG) begin
      wr_hit = 1'b1;
    end else if (widx == otr_pkg::IDX_SYNC_HIGH) begin
      wr_hit = 1'b1;
    end else if (widx == otr_pkg::IDX_SYNC_LENGTH) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Configuration storage, written through byte lane 0 only
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      thresh_cfg_reg <= otr_pkg::THRESH_CFG_RST;
      sync_high_reg  <= otr_pkg::SYNC_HIGH_RST;
      sync_len_reg   <= otr_pkg::SYNC_LENGTH_RST;
    end else if (do_write && wstrb_reg[0]) begin
      if (widx == otr_pkg::IDX_THRESH_CFG) begin
        thresh_cfg_reg <= wdata_reg[7:0];
      end else if (widx == otr_pkg::IDX_SYNC_HIGH) begin
        sync_high_reg <= wdata_reg[7:0];
      end else if (widx == otr_pkg::IDX_SYNC_LENGTH) begin
        sync_len_reg <= wdata_reg[otr_pkg::SLEN_HI:otr_pkg::SLEN_LO];
      end
    end
  end

  // Write response
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= otr_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? otr_pkg::RESP_OKAY : otr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // Read decode; strength is sampled live at the read
  assign ridx = 8'(s_axi_araddr >> ADDR_LSB_U);
  always_comb begin
    rd_next    = '0;
    rresp_next = otr_pkg::RESP_OKAY;
    if (ridx == otr_pkg::IDX_STRENGTH) begin
      rd_next[7:0] = strength_value;
    end else if (ridx == otr_pkg::IDX_THRESH_CFG) begin
      rd_next[7:0] = thresh_cfg_reg;
    end else if (ridx == otr_pkg::IDX_SYNC_HIGH) begin
      rd_next[7:0] = sync_high_reg;
    end else if (ridx == otr_pkg::IDX_SYNC_LENGTH) begin
      rd_next[otr_pkg::SLEN_HI:otr_pkg::SLEN_LO] = sync_len_reg;
    end else begin
      rresp_next = otr_pkg::RESP_SLVERR;
    end
  end

  assign s_axi_arready = !rvalid_reg;
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= otr_pkg::RESP_OKAY;
      rdata_reg  <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rd_next;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;

  // Step size in half-dB units and sync length in bits
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      step_half_db_reg <= 5'h01;
      sync_bits_reg    <= 6'h20;
    end else begin
      case (thresh_cfg_reg[otr_pkg::STEP_HI:otr_pkg::STEP_LO])
        3'h0:    step_half_db_reg <= 5'h01;
        3'h1:    step_half_db_reg <= 5'h02;
        3'h2:    step_half_db_reg <= 5'h03;
        3'h3:    step_half_db_reg <= 5'h04;
        3'h4:    step_half_db_reg <= 5'h06;
        3'h5:    step_half_db_reg <= 5'h08;
        3'h6:    step_half_db_reg <= 5'h0A;
        default: step_half_db_reg <= 5'h0C;
      endcase
      sync_bits_reg <= 6'({1'b0, sync_len_reg} + 3'h1) * otr_pkg::SYNC_BYTE_BITS;
    end
  end

  // Decrement pacing runs from the rate field
  otr_pace_if pace_if (
    .clk   (ref_clk),
    .rst_n (rst_n_reg)
  );
  assign pace_if.rate_code = thresh_cfg_reg[otr_pkg::RATE_HI:otr_pkg::RATE_LO];
  otr_pacer #(
    .CHIP_LOG2 (CHIP_LOG2)
  ) u_pacer (
    .pace (pace_if.pacer)
  );

  // Configuration outputs
  assign threshold_step_size      = thresh_cfg_reg[otr_pkg::STEP_HI:otr_pkg::STEP_LO];
  assign threshold_step_half_db   = step_half_db_reg;
  assign threshold_decrement_rate = thresh_cfg_reg[otr_pkg::RATE_HI:otr_pkg::RATE_LO];
  assign threshold_decrement      = pace_if.decrement_pulse;
  assign average_cutoff_select    = thresh_cfg_reg[otr_pkg::CUT_HI:otr_pkg::CUT_LO];
  assign average_cutoff_narrow    = (average_cutoff_select == otr_pkg::CUT_BR_32PI);
  // Flags a reserved cut-off code left by the host; stored as written
  assign average_cutoff_reserved  = (average_cutoff_select != otr_pkg::CUT_BR_8PI)
                                    && !average_cutoff_narrow;
  assign sync_pattern_value       = sync_high_reg;
  assign sync_length_select       = sync_len_reg;
  assign sync_length_bits         = sync_bits_reg;
endmodule : otr_regs
`default_nettype wire

// [verif/otr_host_model.sv]
// Host bus master model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module otr_host_model (
  input  wire logic        clk,
  output var  logic [11:0] awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [11:0] araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  // Cycles to hold off bready or rready once the answer shows
  int ready_lag = 0;
  // Idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // One write; released address and data show the inverse (wstrb keeps its value) so stale values never pass
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (ready_lag == 0);
    while (aw_p || w_p) begin
      @(posedge clk);
      if (aw_p && awready === 1'b1) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
        aw_p = 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        wvalid <= 1'b0;
        wdata <= ~d;
        w_p = 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    if (ready_lag != 0) begin
      repeat (ready_lag) @(posedge clk);
      bready <= 1'b1;
      @(posedge clk);
      while (bvalid !== 1'b1) @(posedge clk);
    end
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  // One read
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (ready_lag == 0);
    @(posedge clk);
    while (arready !== 1'b1) @(posedge clk);
    arvalid <= 1'b0;
    araddr <= ~a;
    while (rvalid !== 1'b1) @(posedge clk);
    if (ready_lag != 0) begin
      repeat (ready_lag) @(posedge clk);
      rready <= 1'b1;
      @(posedge clk);
      while (rvalid !== 1'b1) @(posedge clk);
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd
endmodule : otr_host_model
`default_nettype wire

// [verif/otr_regs_properties.sv]
// Port-level checks of the threshold, strength and sync register slice
`timescale 1ns/1ps
`default_nettype none
module otr_regs_properties #(
  parameter int ADDR_W = 12
) (
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [7:0]        strength_value,
  input wire logic [2:0]        threshold_step_size,
  input wire logic [4:0]        threshold_step_half_db,
  input wire logic [1:0]        average_cutoff_select,
  input wire logic              average_cutoff_narrow,
  input wire logic [7:0]        sync_pattern_value,
  input wire logic [1:0]        sync_length_select,
  input wire logic [5:0]        sync_length_bits
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Step code to half-dB count
  function automatic logic [4:0] half_db(input logic [2:0] c);
    return (c < 3'h4) ? 5'(c) + 5'h01 : 5'(c) * 5'h02 - 5'h02;
  endfunction : half_db
  // Read taken, then answered
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_strength;
    rd_taken ##0 (s_axi_araddr == {otr_pkg::IDX_STRENGTH, 2'h0});
  endsequence
  a_strength_live: assert property (rd_strength |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(strength_value)})
    else $error("strength read does not show the live sample");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above the low byte not zero");
  a_step_table: assert property ($stable(threshold_step_size) |-> threshold_step_half_db == half_db(threshold_step_size))
    else $error("step size decode wrong");
  a_cut_narrow: assert property ($stable(average_cutoff_select) |-> average_cutoff_narrow == (average_cutoff_select == otr_pkg::CUT_BR_32PI))
    else $error("narrow cut-off flag wrong");
  a_length_table: assert property ($stable(sync_length_select) |-> sync_length_bits == 6'(sync_length_select) * 6'h08 + 6'h08)
    else $error("sync length decode wrong");
  a_reset_values: assert property ($rose(reset_n) |-> threshold_step_size == 3'h0 && average_cutoff_select == 2'h0 && sync_pattern_value == 8'h00 && sync_length_select == 2'h3)
    else $error("configuration not at reset value");
  a_read_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed");
  a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed");
endmodule : otr_regs_properties
bind otr_regs otr_regs_properties #(
  .ADDR_W (ADDR_W)
) u_props (
  .ref_clk                (ref_clk),
  .reset_n                (reset_n),
  .s_axi_araddr           (s_axi_araddr),
  .s_axi_arvalid          (s_axi_arvalid),
  .s_axi_arready          (s_axi_arready),
  .s_axi_rdata            (s_axi_rdata),
  .s_axi_rvalid           (s_axi_rvalid),
  .s_axi_rready           (s_axi_rready),
  .s_axi_bresp            (s_axi_bresp),
  .s_axi_bvalid           (s_axi_bvalid),
  .s_axi_bready           (s_axi_bready),
  .strength_value         (strength_value),
  .threshold_step_size    (threshold_step_size),
  .threshold_step_half_db (threshold_step_half_db),
  .average_cutoff_select  (average_cutoff_select),
  .average_cutoff_narrow  (average_cutoff_narrow),
  .sync_pattern_value     (sync_pattern_value),
  .sync_length_select     (sync_length_select),
  .sync_length_bits       (sync_length_bits)
);
`default_nettype wire

// [verif/otr_regs_test.sv]
// Self-checking bench of the register slice
`timescale 1ns/1ps
`default_nettype none
module otr_regs_test;
  localparam int CHIP_LOG2 = 4; // 16 clocks per chip keeps pulse counts short
  localparam int LIMIT     = 10000;
  typedef struct packed {logic [11:0] addr; logic [7:0] data; logic [3:0] strb; logic [7:0] rd; logic [1:0] resp;} otr_row_s;
  localparam otr_row_s ROWS [8] = '{'{12'h054, 8'hE7, 4'h1, 8'hE7, 2'h0}, '{12'h054, 8'h1C, 4'h1, 8'h1C, 2'h0},
    '{12'h054, 8'h55, 4'h0, 8'h1C, 2'h0}, '{12'h058, 8'hA5, 4'hF, 8'hA5, 2'h0}, '{12'h058, 8'h5A, 4'h1, 8'h5A, 2'h0},
    '{12'h048, 8'h10, 4'h1, 8'h10, 2'h0}, '{12'h050, 8'h33, 4'h1, 8'h9C, 2'h0}, '{12'h03C, 8'h77, 4'h1, 8'h00, 2'h2}};
  localparam logic [4:0] HALF [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C};
  logic        ref_clk = 1'b0;
  logic        reset_n;
  logic [7:0]  strength;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [4:0]  half_db;
  logic [5:0]  len_bits;
  logic        pulse, narrow;
  logic        rsvd;
  logic [2:0]  rate;
  logic [7:0]  pattern;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // Clock and hang guard
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      error_cnt++;
      summarize();
    end
  end
  otr_host_model host (.clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  otr_regs #(.ADDR_W(12), .CHIP_LOG2(CHIP_LOG2)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .strength_value(strength), .threshold_step_size(), .threshold_step_half_db(half_db),
    .threshold_decrement_rate(rate), .threshold_decrement(pulse), .average_cutoff_select(),
    .average_cutoff_narrow(narrow), .average_cutoff_reserved(rsvd), .sync_pattern_value(pattern),
    .sync_length_select(), .sync_length_bits(len_bits));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // Reset values, table rows, decoders, pacing, second reset
  initial begin : main
    otr_row_s    r;
    logic [31:0] d;
    logic [31:0] n;
    logic [1:0]  rs;
    reset_n = 1'b0;
    strength = 8'h9C;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    host.rd(12'h054, d, rs);
    chk(d, 32'h0);
    host.rd(12'h058, d, rs);
    chk(d, 32'h0);
    host.rd(12'h048, d, rs);
    chk(d, 32'h18);
    chk(32'(len_bits), 32'h20);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      host.ready_lag = i % 3;
      host.wr(r.addr, {24'h0, r.data}, r.strb, rs);
      chk({30'h0, rs}, {30'h0, r.resp});
      host.rd(r.addr, d, rs);
      chk(d, {24'h0, r.rd});
      chk({30'h0, rs}, {30'h0, r.resp});
    end
    host.ready_lag = 0;
    chk(32'(pattern), 32'h5A);
    for (int i = 0; i < 4; i++) begin
      host.wr(12'h048, 32'(i) << 3, 4'h1, rs);
      chk(32'(len_bits), 32'(8 * (i + 1)));
    end
    for (int c = 0; c < 8; c++) begin
      host.wr(12'h054, 32'((c << 5) | (c << 2) | ((c % 2) * 3)), 4'h1, rs);
      repeat (130) @(posedge ref_clk);
      n = 32'h0;
      repeat (128) begin
        @(posedge ref_clk);
        n = n + {31'h0, pulse};
      end
      chk(n, (c < 4) ? 32'(8 >> c) : 32'(16 << (c - 4)));
      chk(32'(half_db), 32'(HALF[c]));
      chk({31'h0, narrow}, 32'(c % 2));
      chk(32'(rate), 32'(c));
      chk({31'h0, rsvd}, 32'h0);
    end
    reset_n <= 1'b0;
    strength <= 8'h3E;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    host.rd(12'h054, d, rs);
    chk(d, 32'h0);
    host.rd(12'h058, d, rs);
    chk(d, 32'h0);
    host.rd(12'h050, d, rs);
    chk(d, 32'h3E);
    summarize();
  end
endmodule : otr_regs_test
`default_nettype wire
